// ### part_capture.sv
// one input capture channel: edge detect, latch, sticky flag
// assumes the capture pin is synchronous to i_ref_clk
`timescale 1ns/1ps
`default_nettype none
module part_capture (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_rising,
  input wire logic i_value_read,
  input wire logic [7:0] i_count,
  input wire logic i_pin,
  // state
  output logic o_flag,
  output logic [7:0] o_value
);
  logic pin_q;
  logic flag_q;
  logic [7:0] value_q;
  logic edge_hit;
  assign edge_hit = i_rising ? (i_pin & ~pin_q) : (~i_pin & pin_q);
  assign o_flag = flag_q;
  assign o_value = value_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_q <= 1'b0;
      flag_q <= 1'b0;
      value_q <= part_pkg::REG_RESET;
    end else begin
      pin_q <= i_pin;
      if (edge_hit && !flag_q) begin
        flag_q <= 1'b1;
        value_q <= i_count;
      end else if (i_value_read) begin
        flag_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### part_pkg.sv
// package for the 8-bit auto-reload pwm timer: register map, fields, resets
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package part_pkg;
  localparam logic [7:0] ADDR_DUTY3 = 8'h31;
  localparam logic [7:0] ADDR_DUTY2 = 8'h32;
  localparam logic [7:0] ADDR_DUTY1 = 8'h33;
  localparam logic [7:0] ADDR_DUTY0 = 8'h34;
  localparam logic [7:0] ADDR_PWM_CTRL = 8'h35;
  localparam logic [7:0] ADDR_TIMER_CS = 8'h36;
  localparam logic [7:0] ADDR_CNT_LIVE = 8'h37;
  localparam logic [7:0] ADDR_RELOAD = 8'h38;
  localparam logic [7:0] ADDR_CAP_CS = 8'h39;
  localparam logic [7:0] ADDR_CAP_VAL1 = 8'h3a;
  localparam logic [7:0] ADDR_CAP_VAL2 = 8'h3b;
  // timer_control_status field positions
  localparam int BIT_EXT_CLK = 7;
  localparam int BIT_PRESC_HI = 6;
  localparam int BIT_PRESC_LO = 4;
  localparam int BIT_RUN = 3;
  localparam int BIT_FORCE_RELOAD = 2;
  localparam int BIT_OVF_IE = 1;
  localparam int BIT_OVF = 0;
  // capture_control_status field positions
  localparam int BIT_CAP_EDGE_LO = 4;
  localparam int BIT_CAP_IE_LO = 2;
  localparam int BIT_CAP_FLAG_LO = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [6:0] PRESC_RESET = 7'h00;
  // software request from the register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } part_bus_s;
endpackage
`default_nettype wire

// ### part_prescaler.sv
// 7-bit prescaler producing a one-cycle counter tick
// assumes the external clock input is already synchronous to i_ref_clk
`timescale 1ns/1ps
`default_nettype none
module part_prescaler #(
  parameter int WIDTH = 7
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_run,
  input wire logic i_clear,
  input wire logic i_ext_sel,
  input wire logic i_ext_clk,
  input wire logic [2:0] i_div_sel,
  // tick out
  output logic o_tick
);
  if (WIDTH != 7) begin : g_bad_width
    $error("prescaler width must be 7");
  end
  logic [WIDTH-1:0] count_q;
  logic ext_q;
  logic in_pulse;
  logic [WIDTH-1:0] mask;
  // external clock counts on its rising edges only
  assign in_pulse = i_ext_sel ? (i_ext_clk & ~ext_q) : 1'b1;
  assign mask = WIDTH'((8'h01 << i_div_sel) - 8'h01);
  // divide by two to the select
  assign o_tick = i_run & in_pulse & ((count_q & mask) == mask);
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q <= part_pkg::PRESC_RESET;
      ext_q <= 1'b0;
    end else begin
      ext_q <= i_ext_clk;
      if (i_clear) begin
        count_q <= part_pkg::PRESC_RESET;
      end else if (i_run && in_pulse) begin
        count_q <= count_q + 7'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### part_timer.sv
// 8-bit auto-reload pwm timer with four pwm outputs and two captures
// assumes inputs synchronous to i_ref_clk and a one-cycle strobe bus
`timescale 1ns/1ps
`default_nettype none
module part_timer #(
  parameter int CHANNELS = 4,
  parameter int CAPTURES = 2
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // pins
  input wire logic i_ext_clk,
  input wire logic [CAPTURES-1:0] i_capture_pin,
  output logic [CHANNELS-1:0] o_pwm,
  output logic [CHANNELS-1:0] o_pwm_oe_n,
  // interrupt requests
  output logic o_overflow_irq,
  output logic [CAPTURES-1:0] o_capture_irq
);
  // the register map only has room for four channels and two captures
  if (CHANNELS != 4 || CAPTURES != 2) begin : g_bad_size
    $error("four pwm channels and two captures are required");
  end

  part_pkg::part_bus_s bus;
  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  // decoded strobes
  logic wr_duty3, wr_duty2, wr_duty1, wr_duty0;
  logic wr_pwm_ctrl, wr_timer_cs, wr_cnt_live, wr_reload, wr_cap_cs;
  logic rd_timer_cs, rd_cap1, rd_cap2;
  assign wr_duty3 = bus.wr & hit(bus.addr, part_pkg::ADDR_DUTY3);
  assign wr_duty2 = bus.wr & hit(bus.addr, part_pkg::ADDR_DUTY2);
  assign wr_duty1 = bus.wr & hit(bus.addr, part_pkg::ADDR_DUTY1);
  assign wr_duty0 = bus.wr & hit(bus.addr, part_pkg::ADDR_DUTY0);
  assign wr_pwm_ctrl = bus.wr & hit(bus.addr, part_pkg::ADDR_PWM_CTRL);
  assign wr_timer_cs = bus.wr & hit(bus.addr, part_pkg::ADDR_TIMER_CS);
  assign wr_cnt_live = bus.wr & hit(bus.addr, part_pkg::ADDR_CNT_LIVE);
  assign wr_reload = bus.wr & hit(bus.addr, part_pkg::ADDR_RELOAD);
  assign wr_cap_cs = bus.wr & hit(bus.addr, part_pkg::ADDR_CAP_CS);
  assign rd_timer_cs = bus.rd & hit(bus.addr, part_pkg::ADDR_TIMER_CS);
  assign rd_cap1 = bus.rd & hit(bus.addr, part_pkg::ADDR_CAP_VAL1);
  assign rd_cap2 = bus.rd & hit(bus.addr, part_pkg::ADDR_CAP_VAL2);

  // software registers
  logic [7:0] duty_q [CHANNELS];
  logic [7:0] compare_q [CHANNELS];
  logic [7:0] pwm_ctrl_q;
  logic [7:0] timer_cs_q;
  logic [7:0] reload_q;
  logic [5:0] cap_cs_q;
  logic [7:0] count_q;
  logic [CHANNELS-1:0] start_q;
  logic ovf_q;
  logic [7:0] rdata_q;

  // control fields
  logic ext_sel, run, ovf_ie, force_reload;
  logic [2:0] div_sel;
  logic [CAPTURES-1:0] cap_edge, cap_ie, cap_flag;
  logic [7:0] cap_val [CAPTURES];
  logic tick, overflow, presc_clear;
  assign ext_sel = timer_cs_q[part_pkg::BIT_EXT_CLK];
  assign div_sel = timer_cs_q[part_pkg::BIT_PRESC_HI:part_pkg::BIT_PRESC_LO];
  assign run = timer_cs_q[part_pkg::BIT_RUN];
  assign ovf_ie = timer_cs_q[part_pkg::BIT_OVF_IE];
  assign force_reload = wr_timer_cs & bus.wdata[part_pkg::BIT_FORCE_RELOAD];
  assign cap_edge = cap_cs_q[part_pkg::BIT_CAP_EDGE_LO +: CAPTURES];
  assign cap_ie = cap_cs_q[part_pkg::BIT_CAP_IE_LO +: CAPTURES];
  // counter write also restarts the prescaler from a known point
  assign presc_clear = force_reload | wr_cnt_live;
  // overflow is the tick at maximum count
  assign overflow = tick & (count_q == part_pkg::CNT_MAX);

  part_prescaler #(
    .WIDTH(7)
  ) u_presc (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_run(run),
    .i_clear(presc_clear),
    .i_ext_sel(ext_sel),
    .i_ext_clk(i_ext_clk),
    .i_div_sel(div_sel),
    .o_tick(tick)
  );

  // register storage
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwm_ctrl_q <= part_pkg::REG_RESET;
      timer_cs_q <= part_pkg::REG_RESET;
      reload_q <= part_pkg::REG_RESET;
      cap_cs_q <= 6'h00;
    end else begin
      if (wr_pwm_ctrl) begin
        pwm_ctrl_q <= bus.wdata;
      end
      // force reload bit is never stored
      if (wr_timer_cs) begin
        timer_cs_q <= {bus.wdata[7:3], 1'b0, bus.wdata[1:0]};
      end
      if (wr_reload) begin
        reload_q <= bus.wdata;
      end
      // flag bits of the capture status are hardware owned
      if (wr_cap_cs) begin
        cap_cs_q <= {bus.wdata[5:2], 2'b00};
      end
    end
  end

  // counter and overflow flag
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q <= part_pkg::REG_RESET;
      ovf_q <= 1'b0;
    end else begin
      if (force_reload) begin
        count_q <= reload_q;
      end else if (wr_cnt_live) begin
        count_q <= bus.wdata;
      end else if (overflow) begin
        count_q <= reload_q;
      end else if (tick) begin
        count_q <= count_q + 8'h01;
      end
      if (overflow) begin
        ovf_q <= 1'b1;
      end else if (rd_timer_cs) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // duty registers, hidden compares, period-start state
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      logic wr_duty;
      logic cmp_high;
      // duty_cycle_ch0 sits at the highest offset
      assign wr_duty = (g == 0) ? wr_duty0 : (g == 1) ? wr_duty1 :
                       (g == 2) ? wr_duty2 : wr_duty3;
      assign cmp_high = (count_q <= compare_q[g]);
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          duty_q[g] <= part_pkg::REG_RESET;
          compare_q[g] <= part_pkg::REG_RESET;
          start_q[g] <= 1'b0;
        end else begin
          if (wr_duty) begin
            duty_q[g] <= bus.wdata;
          end
          if (overflow) begin
            compare_q[g] <= duty_q[g];
          end
          start_q[g] <= cmp_high;
        end
      end
      // polarity applied combinationally, acts at once
      // second edge where counter passes compare
      assign o_pwm[g] = (start_q[g] ^ pwm_ctrl_q[g]) & pwm_ctrl_q[g + 4];
      assign o_pwm_oe_n[g] = ~pwm_ctrl_q[g + 4];
    end
  endgenerate

  // capture channels
  logic [CAPTURES-1:0] cap_read;
  assign cap_read = {rd_cap2, rd_cap1};
  generate
    for (g = 0; g < CAPTURES; g++) begin : g_cap
      part_capture u_cap (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_rising(cap_edge[g]),
        .i_value_read(cap_read[g]),
        .i_count(count_q),
        .i_pin(i_capture_pin[g]),
        .o_flag(cap_flag[g]),
        .o_value(cap_val[g])
      );
    end
  endgenerate

  assign o_overflow_irq = ovf_ie & ovf_q;
  assign o_capture_irq = cap_ie & cap_flag;

  // read mux; unmapped offsets read zero
  logic [7:0] rdata_d;
  assign rdata_d =
    hit(bus.addr, part_pkg::ADDR_DUTY3) ? duty_q[3] :
    hit(bus.addr, part_pkg::ADDR_DUTY2) ? duty_q[2] :
    hit(bus.addr, part_pkg::ADDR_DUTY1) ? duty_q[1] :
    hit(bus.addr, part_pkg::ADDR_DUTY0) ? duty_q[0] :
    hit(bus.addr, part_pkg::ADDR_PWM_CTRL) ? pwm_ctrl_q :
    hit(bus.addr, part_pkg::ADDR_TIMER_CS) ? {timer_cs_q[7:1], ovf_q} :
    hit(bus.addr, part_pkg::ADDR_CNT_LIVE) ? count_q :
    hit(bus.addr, part_pkg::ADDR_RELOAD) ? reload_q :
    hit(bus.addr, part_pkg::ADDR_CAP_CS) ? {2'b00, cap_cs_q[5:2], cap_flag} :
    hit(bus.addr, part_pkg::ADDR_CAP_VAL1) ? cap_val[0] :
    hit(bus.addr, part_pkg::ADDR_CAP_VAL2) ? cap_val[1] :
    8'h00;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= part_pkg::REG_RESET;
    end else if (bus.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign o_rdata = rdata_q;
endmodule
`default_nettype wire

// ### part_timer_props.sv
// checker for part_timer: register port and pin relations
// assumes one clock and the one-cycle strobe register port
`timescale 1ns/1ps
`default_nettype none
module part_timer_props #(
  parameter int CHANNELS = 4,
  parameter int CAPTURES = 2
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // pins and requests
  input wire logic i_ext_clk,
  input wire logic [CAPTURES-1:0] i_capture_pin,
  input wire logic [CHANNELS-1:0] o_pwm,
  input wire logic [CHANNELS-1:0] o_pwm_oe_n,
  input wire logic o_overflow_irq,
  input wire logic [CAPTURES-1:0] o_capture_irq
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rd(a);
    i_rd && i_addr == a;
  endsequence
  a_ovf_irq_gate: assert property (
    s_rd(part_pkg::ADDR_TIMER_CS) |=>
    (o_rdata[1] & o_rdata[0]) == $past(o_overflow_irq))
    else $error("overflow request differs from enable and flag");
  a_force_reads_zero: assert property (
    s_rd(part_pkg::ADDR_TIMER_CS) |=> !o_rdata[2])
    else $error("force reload bit read back as one");
  a_cap_top_zero: assert property (
    s_rd(part_pkg::ADDR_CAP_CS) |=> o_rdata[7:6] == 2'b00)
    else $error("capture status top bits not zero");
  a_cap_irq_gate: assert property (
    s_rd(part_pkg::ADDR_CAP_CS) |=>
    (o_rdata[3:2] & o_rdata[1:0]) == $past(o_capture_irq))
    else $error("capture request differs from enable and flag");
  a_oe_follows_reg: assert property (
    i_wr && i_addr == part_pkg::ADDR_PWM_CTRL |=>
    o_pwm_oe_n == ~$past(i_wdata[7:4]))
    else $error("output enable does not follow control write");
  a_pwm_idle_off: assert property (
    (o_pwm & o_pwm_oe_n) == '0)
    else $error("disabled channel drives a one");
  a_cap_flag_clear: assert property (
    s_rd(part_pkg::ADDR_CAP_VAL1) ##0 o_capture_irq[0] |=>
    !o_capture_irq[0])
    else $error("capture flag not cleared by value read");
  a_cap_edge_set: assert property (
    $rose(o_capture_irq[0]) && !$past(i_wr) |->
    $past(i_capture_pin[0]) != $past(i_capture_pin[0], 2))
    else $error("capture request rose without a pin edge");
endmodule
bind part_timer part_timer_props #(.CHANNELS(CHANNELS), .CAPTURES(CAPTURES))
  u_props (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_ext_clk(i_ext_clk), .i_capture_pin(i_capture_pin), .o_pwm(o_pwm),
  .o_pwm_oe_n(o_pwm_oe_n), .o_overflow_irq(o_overflow_irq),
  .o_capture_irq(o_capture_irq));
`default_nettype wire

// ### tb_top.sv
// testbench for part_timer: register tasks, queued read checks, pin checks
// assumes part_pkg and part_timer compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_ext_clk = 1'b0;
  logic [1:0] i_capture_pin = 2'b00;
  logic [7:0] o_rdata;
  logic [3:0] o_pwm;
  logic [3:0] o_pwm_oe_n;
  logic o_overflow_irq;
  logic [1:0] o_capture_irq;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] duty [4];
  int error_cnt = 0;
  int checks = 0;
  localparam logic [7:0] TC = part_pkg::ADDR_TIMER_CS;
  localparam logic [7:0] CT = part_pkg::ADDR_CNT_LIVE;
  localparam logic [7:0] CC = part_pkg::ADDR_CAP_CS;
  localparam logic [7:0] D0 = part_pkg::ADDR_DUTY0;

  always #2.5 i_ref_clk = ~i_ref_clk;

  part_timer dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_ext_clk(i_ext_clk), .i_capture_pin(i_capture_pin), .o_pwm(o_pwm),
    .o_pwm_oe_n(o_pwm_oe_n), .o_overflow_irq(o_overflow_irq),
    .o_capture_irq(o_capture_irq));

  task automatic wrap_up();
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic bad(input string m);
    error_cnt++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] e);
    checks++;
    if (got !== e) bad($sformatf("read got %h exp %h", got, e));
  endtask

  task automatic chk_pin(input logic [3:0] got, input logic [3:0] e);
    checks++;
    if (got !== e) bad($sformatf("pins got %h exp %h", got, e));
  endtask

  // strobes are set on every call so back-to-back calls never clash
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    @(posedge i_ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    exp_q.push_back(e);
    @(posedge i_ref_clk);
  endtask

  task automatic idle(input int n);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (n) @(posedge i_ref_clk);
  endtask

  // 0 pwm levels, 1 requests, 2 output enables; sampled mid-cycle
  task automatic look(input logic [1:0] s, input logic [3:0] e);
    idle(0);
    @(negedge i_ref_clk);
    chk_pin(s == 2'd0 ? o_pwm : s == 2'd1 ?
      {1'b0, o_capture_irq, o_overflow_irq} : o_pwm_oe_n, e);
    @(posedge i_ref_clk);
  endtask

  function automatic logic [3:0] pw(input logic [7:0] c,
                                    input logic [3:0] p);
    for (int j = 0; j < 4; j++) pw[j] = (c <= duty[j]) ^ p[j];
  endfunction

  task automatic pin_pair(input logic [1:0] a, input logic [1:0] b);
    i_capture_pin <= a;
    idle(2);
    i_capture_pin <= b;
    idle(3);
  endtask

  always @(posedge i_ref_clk) begin
    if (rd_q) chk_rd(o_rdata, exp_q.pop_front());
    rd_q <= i_rd;
  end

  initial begin
    repeat (100000) @(posedge i_ref_clk);
    bad("timeout");
    wrap_up();
  end

  initial begin
    void'($urandom(32'ha5a7b0cb));
    foreach (duty[i]) duty[i] = 8'($urandom_range(254));
    repeat (2) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    idle(1);
    look(2, 4'hf);
    for (int a = 8'h30; a < 8'h3d; a++) rd(8'(a), 8'h00);
    foreach (duty[i]) wr(D0 - 8'(i), duty[i]);
    foreach (duty[i]) rd(D0 - 8'(i), duty[i]);
    wr(part_pkg::ADDR_RELOAD, 8'h5a);
    wr(CC, 8'hff);
    rd(CC, 8'h3c);
    wr(TC, 8'h06);
    rd(TC, 8'h02);
    rd(CT, 8'h5a);
    wr(CT, 8'hfd);
    rd(CT, 8'hfd);
    wr(TC, 8'h0a);
    idle(20);
    look(1, 4'h1);
    rd(TC, 8'h0b);
    rd(TC, 8'h0a);
    wr(TC, 8'h00);
    // divide by 128: no overflow at 100 cycles, one by 140
    wr(CT, 8'hff);
    wr(TC, 8'h78);
    idle(100);
    rd(TC, 8'h78);
    idle(40);
    rd(TC, 8'h79);
    wr(TC, 8'h00);
    wr(CT, 8'hfe);
    wr(TC, 8'h88);
    idle(30);
    rd(TC, 8'h88);
    pin_pair(2'b00, 2'b00);
    repeat (4) begin
      i_ext_clk <= ~i_ext_clk;
      idle(2);
    end
    idle(3);
    rd(TC, 8'h89);
    rd(CT, 8'h5a);
    wr(TC, 8'h00);
    wr(part_pkg::ADDR_PWM_CTRL, 8'hf0);
    foreach (duty[i]) begin
      for (int k = 0; k < 2; k++) begin
        wr(CT, duty[i] + 8'(k));
        idle(2);
        look(0, pw(duty[i] + 8'(k), 4'h0));
      end
    end
    foreach (duty[i]) wr(D0 - 8'(i), ~duty[i]);
    wr(CT, duty[0]);
    idle(2);
    look(0, pw(duty[0], 4'h0));
    wr(part_pkg::ADDR_PWM_CTRL, 8'hf5);
    look(0, pw(duty[0], 4'h5));
    wr(part_pkg::ADDR_PWM_CTRL, 8'h35);
    look(0, pw(duty[0], 4'h5) & 4'h3);
    look(2, 4'hc);
    wr(CT, 8'h3c);
    wr(CC, 8'h2c);
    i_capture_pin <= 2'b01;
    idle(3);
    rd(CC, 8'h2c);
    i_capture_pin <= 2'b10;
    idle(3);
    look(1, 4'h6);
    rd(CC, 8'h2f);
    wr(CT, 8'h77);
    pin_pair(2'b01, 2'b10);
    rd(part_pkg::ADDR_CAP_VAL1, 8'h3c);
    rd(part_pkg::ADDR_CAP_VAL2, 8'h3c);
    rd(CC, 8'h2c);
    wr(CC, 8'h20);
    pin_pair(2'b01, 2'b10);
    look(1, 4'h0);
    rd(CC, 8'h23);
    rd(part_pkg::ADDR_CAP_VAL1, 8'h77);
    rd(part_pkg::ADDR_CAP_VAL2, 8'h77);
    idle(3);
    if (exp_q.size() != 0) bad("reads left unanswered");
    wrap_up();
  end
endmodule
`default_nettype wire
